// File: shared/pfs_pkg.sv
// Package for the processor field and stack register file.
// Assumes a single synchronous clock domain.
package pfs_pkg;
  localparam int WORD_W      = 24;
  localparam int NIB_W       = 4;
  localparam int NIB_N       = 6;
  localparam int DESC_W      = 48;
  localparam int LEN_W       = 16;
  localparam int STACK_WORDS = 33;
  localparam int PTR_W       = 5;
  localparam int MAP_W       = 18;
  localparam int SEL_W       = 5;
  localparam int SH_W        = 5;

  // Descriptor field positions
  localparam int FA_LSB  = 24;
  localparam int FU_LSB  = 20;
  localparam int FT_LSB  = 16;
  localparam int FL_LSB  = 0;

  localparam logic [NIB_W-1:0] UNIT_BINARY = 4'h0;
  localparam logic [NIB_W-1:0] UNIT_PACKED = 4'h4;
  localparam logic [LEN_W-1:0] LEN_ZERO    = 16'h0000;
  localparam logic [LEN_W-1:0] LEN_ONE     = 16'h0001;
  localparam logic [WORD_W-1:0] WORD_ZERO  = 24'h000000;
  localparam logic [PTR_W-1:0] PTR_ZERO    = 5'h00;
  localparam logic [PTR_W-1:0] PTR_ONE     = 5'h01;

  // Register selectors
  typedef enum logic [SEL_W-1:0] {
    SEL_NONE, SEL_GEN_L, SEL_GEN_T, SEL_OP_X, SEL_OP_Y, SEL_STACK,
    SEL_DESC_ADDR, SEL_DESC_LOW, SEL_UNIT, SEL_KIND, SEL_LEN,
    SEL_LA, SEL_LB, SEL_LC, SEL_LD, SEL_LE, SEL_LF,
    SEL_TA, SEL_TB, SEL_TC, SEL_TD, SEL_TE, SEL_TF,
    SEL_LEN_C, SEL_LEN_D, SEL_LEN_E, SEL_LEN_F
  } pfs_sel_e;

  // Datapath operations
  typedef enum logic [3:0] {
    OP_NONE, OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_XY_SHL, OP_XY_SHR, OP_XY_ROL, OP_XY_ROR,
    OP_EXTRACT_T, OP_LEN_INC, OP_LEN_DEC, OP_DESC_STORE, OP_DESC_LOAD, OP_DESC_SWAP,
    OP_BIAS_UNIT
  } pfs_op_e;

  typedef struct packed {
    logic                 valid;
    pfs_sel_e             src;
    pfs_sel_e             dst;
    logic [WORD_W-1:0]    wdata;
  } pfs_move_s;

  typedef struct packed {
    logic                 valid;
    pfs_op_e              op;
    pfs_sel_e             target;
    logic [SH_W-1:0]      amount;
    logic [SH_W-1:0]      width;
    logic [DESC_W-1:0]    pad;
  } pfs_op_s;
endpackage

// File: hw/pfs_regs.sv
// Register file: general, operand, stack and field-descriptor registers.
// Assumes the decoder issues at most one move and one operation per cycle.
`timescale 1ns/100ps
// Notes on behaviour
// - General register L addressable whole and as six nibble registers.
// - L nibbles feed nibble function box, manipulate, skip and bit tests.
// - General register T likewise split into six nibble registers.
// - T supports extract-field and shift or rotate.
// - X and Y feed the function box; shift/rotate singly and concatenated.
// - X and Y have no nibble sub-registers.
// - X equal to Y offered as a test condition.
// - Stack of 33 words, 32-state pointer, last entry reserved.
// - Stack reached only through the top-of-stack register.
// - Writing top pushes old value then loads new one.
// - Reading top returns it and pops next entry into it.
// - Call pushes next micro address into top then branches.
// - Moving top into micro address register acts as return.
// - 48-bit descriptor stored, loaded, swapped whole with doublepad word.
// - All descriptor subfields usable as source and destination.
// - Field address is 24 bits, absolute bit address.
// - Descriptor low half accessible as one 24-bit entity.
// - Unit subfield 0 binary, 4 packed; bias sets parallelism control.
// - Kind tag subfield is plain storage.
// - Length subfield is 16 bits wide.
// - Length wraps on increment overflow, saturates at zero on decrement.
module pfs_regs #(
  parameter int WORD_W      = pfs_pkg::WORD_W,
  parameter int STACK_WORDS = pfs_pkg::STACK_WORDS
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          clkEn,
  // Moves from the decoder
  input  wire pfs_pkg::pfs_move_s            move,
  output logic [WORD_W-1:0]                  rdata,
  // Operations
  input  wire pfs_pkg::pfs_op_s              op,
  output logic [pfs_pkg::DESC_W-1:0]         padOut,
  // Call and return
  input  wire logic                          call,
  input  wire logic [pfs_pkg::MAP_W-1:0]     nextMicroAddr,
  input  wire logic                          ret,
  output logic [pfs_pkg::MAP_W-1:0]          returnAddr,
  // Status
  output logic                              xyEqual,
  output logic [1:0]                        parallelismControl,
  output logic [pfs_pkg::PTR_W-1:0]          stackDepth,
  output logic [WORD_W-1:0]                  genL,
  output logic [WORD_W-1:0]                  genT,
  output logic [WORD_W-1:0]                  opX,
  output logic [WORD_W-1:0]                  opY
);
  // ==========================================================
  // Storage
  logic [WORD_W-1:0]              lQ, tQ, xQ, yQ, topQ;
  logic [WORD_W-1:0]              stackQ [STACK_WORDS];
  logic [pfs_pkg::PTR_W-1:0]      ptrQ;
  logic [pfs_pkg::DESC_W-1:0]     descQ;
  logic [1:0]                     parQ;
  logic [WORD_W-1:0]              rdataQ;
  logic [pfs_pkg::DESC_W-1:0]     padOutQ;
  logic [pfs_pkg::MAP_W-1:0]      retQ;

  // ==========================================================
  // Helpers
  function automatic logic [WORD_W-1:0] putNib(input logic [WORD_W-1:0] w, input int idx,
                                                input logic [3:0] v);
    logic [WORD_W-1:0] r;
    r = w;
    r[(pfs_pkg::NIB_N-1-idx)*pfs_pkg::NIB_W +: pfs_pkg::NIB_W] = v;
    return r;
  endfunction

  function automatic logic [WORD_W-1:0] shiftWord(input logic [WORD_W-1:0] w,
                                                  input pfs_pkg::pfs_op_e o,
                                                  input logic [pfs_pkg::SH_W-1:0] n);
    logic [2*WORD_W-1:0] d;
    d = {w, w};
    unique case (o)
      pfs_pkg::OP_SHL: return w << n;
      pfs_pkg::OP_SHR: return w >> n;
      pfs_pkg::OP_ROL: begin
        d = d << n;
        return d[2*WORD_W-1 -: WORD_W];
      end
      pfs_pkg::OP_ROR: begin
        d = d >> n;
        return d[WORD_W-1:0];
      end
      default: return w;
    endcase
  endfunction

  function automatic logic [2*WORD_W-1:0] shiftPair(input logic [2*WORD_W-1:0] w,
                                                    input pfs_pkg::pfs_op_e o,
                                                    input logic [pfs_pkg::SH_W-1:0] n);
    logic [4*WORD_W-1:0] d;
    d = {w, w};
    unique case (o)
      pfs_pkg::OP_XY_SHL: return w << n;
      pfs_pkg::OP_XY_SHR: return w >> n;
      pfs_pkg::OP_XY_ROL: begin
        d = d << n;
        return d[4*WORD_W-1 -: 2*WORD_W];
      end
      pfs_pkg::OP_XY_ROR: begin
        d = d >> n;
        return d[2*WORD_W-1:0];
      end
      default: return w;
    endcase
  endfunction

  // ==========================================================
  // Decode
  logic wrEn, rdEn, popTop, pushTop;
  logic [WORD_W-1:0] srcVal;
  logic [WORD_W-1:0] descLow;
  logic [pfs_pkg::LEN_W-1:0] lenQ;

  assign wrEn    = move.valid && (move.dst != pfs_pkg::SEL_NONE);
  assign rdEn    = move.valid && (move.src != pfs_pkg::SEL_NONE);
  assign descLow = descQ[WORD_W-1:0];
  assign lenQ    = descQ[pfs_pkg::FL_LSB +: pfs_pkg::LEN_W];
  assign popTop  = (rdEn && move.src == pfs_pkg::SEL_STACK) || ret;
  assign pushTop = (wrEn && move.dst == pfs_pkg::SEL_STACK) || call;

  always_comb begin
    srcVal = pfs_pkg::WORD_ZERO;
    unique case (move.src)
      pfs_pkg::SEL_GEN_L:     srcVal = lQ;
      pfs_pkg::SEL_GEN_T:     srcVal = tQ;
      pfs_pkg::SEL_OP_X:      srcVal = xQ;
      pfs_pkg::SEL_OP_Y:      srcVal = yQ;
      pfs_pkg::SEL_STACK:     srcVal = topQ;
      pfs_pkg::SEL_DESC_ADDR: srcVal = descQ[pfs_pkg::FA_LSB +: WORD_W];
      pfs_pkg::SEL_DESC_LOW:  srcVal = descLow;
      pfs_pkg::SEL_UNIT:      srcVal = {20'h00000, descQ[pfs_pkg::FU_LSB +: 4]};
      pfs_pkg::SEL_KIND:      srcVal = {20'h00000, descQ[pfs_pkg::FT_LSB +: 4]};
      pfs_pkg::SEL_LEN:       srcVal = {8'h00, lenQ};
      pfs_pkg::SEL_LA, pfs_pkg::SEL_LB, pfs_pkg::SEL_LC,
      pfs_pkg::SEL_LD, pfs_pkg::SEL_LE, pfs_pkg::SEL_LF:
        srcVal = {20'h00000, lQ[(5-(move.src-pfs_pkg::SEL_LA))*4 +: 4]};
      pfs_pkg::SEL_TA, pfs_pkg::SEL_TB, pfs_pkg::SEL_TC,
      pfs_pkg::SEL_TD, pfs_pkg::SEL_TE, pfs_pkg::SEL_TF:
        srcVal = {20'h00000, tQ[(5-(move.src-pfs_pkg::SEL_TA))*4 +: 4]};
      pfs_pkg::SEL_LEN_C, pfs_pkg::SEL_LEN_D, pfs_pkg::SEL_LEN_E,
      pfs_pkg::SEL_LEN_F:
        srcVal = {20'h00000, lenQ[(3-(move.src-pfs_pkg::SEL_LEN_C))*4 +: 4]};
      default:                srcVal = pfs_pkg::WORD_ZERO;
    endcase
  end

  // ==========================================================
  // General registers L and T
  always_ff @(posedge clk) begin
    if (rst) begin
      lQ <= pfs_pkg::WORD_ZERO;
      tQ <= pfs_pkg::WORD_ZERO;
    end else if (clkEn) begin
      if (wrEn) begin
        unique case (move.dst)
          pfs_pkg::SEL_GEN_L: lQ <= move.wdata;
          pfs_pkg::SEL_GEN_T: tQ <= move.wdata;
          pfs_pkg::SEL_LA, pfs_pkg::SEL_LB, pfs_pkg::SEL_LC,
          pfs_pkg::SEL_LD, pfs_pkg::SEL_LE, pfs_pkg::SEL_LF:
            lQ <= putNib(lQ, int'(move.dst - pfs_pkg::SEL_LA), move.wdata[3:0]);
          pfs_pkg::SEL_TA, pfs_pkg::SEL_TB, pfs_pkg::SEL_TC,
          pfs_pkg::SEL_TD, pfs_pkg::SEL_TE, pfs_pkg::SEL_TF:
            tQ <= putNib(tQ, int'(move.dst - pfs_pkg::SEL_TA), move.wdata[3:0]);
          default: ;
        endcase
      end
      if (op.valid && op.target == pfs_pkg::SEL_GEN_T) begin
        if (op.op == pfs_pkg::OP_EXTRACT_T)
          tQ <= (tQ >> op.amount) & ((24'h000001 << op.width) - 24'h000001);
        else if (op.op inside {pfs_pkg::OP_SHL, pfs_pkg::OP_SHR, pfs_pkg::OP_ROL, pfs_pkg::OP_ROR})
          tQ <= shiftWord(tQ, op.op, op.amount);
      end
    end
  end

  // ==========================================================
  // Operand registers X and Y
  always_ff @(posedge clk) begin
    if (rst) begin
      xQ <= pfs_pkg::WORD_ZERO;
      yQ <= pfs_pkg::WORD_ZERO;
    end else if (clkEn) begin
      if (wrEn && move.dst == pfs_pkg::SEL_OP_X) xQ <= move.wdata;
      if (wrEn && move.dst == pfs_pkg::SEL_OP_Y) yQ <= move.wdata;
      if (op.valid) begin
        if (op.op inside {pfs_pkg::OP_XY_SHL, pfs_pkg::OP_XY_SHR, pfs_pkg::OP_XY_ROL,
                          pfs_pkg::OP_XY_ROR})
          {xQ, yQ} <= shiftPair({xQ, yQ}, op.op, op.amount);
        else if (op.target == pfs_pkg::SEL_OP_X)
          xQ <= shiftWord(xQ, op.op, op.amount);
        else if (op.target == pfs_pkg::SEL_OP_Y)
          yQ <= shiftWord(yQ, op.op, op.amount);
      end
    end
  end

  // ==========================================================
  // Stack and top register
  always_ff @(posedge clk) begin
    if (rst) begin
      topQ <= pfs_pkg::WORD_ZERO;
      ptrQ <= pfs_pkg::PTR_ZERO;
      for (int i = 0; i < STACK_WORDS; i++) stackQ[i] <= pfs_pkg::WORD_ZERO;
      retQ <= '0;
    end else if (clkEn) begin
      if (pushTop) begin
        stackQ[ptrQ] <= topQ;
        ptrQ         <= ptrQ + pfs_pkg::PTR_ONE;
        topQ         <= call ? {6'h00, nextMicroAddr} : move.wdata;
      end else if (popTop) begin
        topQ <= stackQ[ptrQ - pfs_pkg::PTR_ONE];
        ptrQ <= ptrQ - pfs_pkg::PTR_ONE;
      end
      if (ret) retQ <= topQ[pfs_pkg::MAP_W-1:0];
    end
  end

  // ==========================================================
  // Field descriptor
  always_ff @(posedge clk) begin
    if (rst) begin
      descQ   <= '0;
      parQ    <= 2'h0;
      padOutQ <= '0;
    end else if (clkEn) begin
      if (wrEn) begin
        unique case (move.dst)
          pfs_pkg::SEL_DESC_ADDR: descQ[pfs_pkg::FA_LSB +: WORD_W] <= move.wdata;
          pfs_pkg::SEL_DESC_LOW:  descQ[WORD_W-1:0] <= move.wdata;
          pfs_pkg::SEL_UNIT:      descQ[pfs_pkg::FU_LSB +: 4] <= move.wdata[3:0];
          pfs_pkg::SEL_KIND:      descQ[pfs_pkg::FT_LSB +: 4] <= move.wdata[3:0];
          pfs_pkg::SEL_LEN:       descQ[pfs_pkg::FL_LSB +: pfs_pkg::LEN_W] <= move.wdata[15:0];
          pfs_pkg::SEL_LEN_C, pfs_pkg::SEL_LEN_D, pfs_pkg::SEL_LEN_E,
          pfs_pkg::SEL_LEN_F:
            descQ[(3-(move.dst-pfs_pkg::SEL_LEN_C))*4 +: 4] <= move.wdata[3:0];
          default: ;
        endcase
      end
      if (op.valid) begin
        unique case (op.op)
          pfs_pkg::OP_LEN_INC:
            descQ[pfs_pkg::FL_LSB +: pfs_pkg::LEN_W] <= lenQ + pfs_pkg::LEN_ONE;
          pfs_pkg::OP_LEN_DEC:
            descQ[pfs_pkg::FL_LSB +: pfs_pkg::LEN_W] <=
              (lenQ == pfs_pkg::LEN_ZERO) ? pfs_pkg::LEN_ZERO : lenQ - pfs_pkg::LEN_ONE;
          pfs_pkg::OP_DESC_STORE: padOutQ <= descQ;
          pfs_pkg::OP_DESC_LOAD:  descQ   <= op.pad;
          pfs_pkg::OP_DESC_SWAP: begin
            padOutQ <= descQ;
            descQ   <= op.pad;
          end
          pfs_pkg::OP_BIAS_UNIT:
            parQ <= {1'b0, descQ[pfs_pkg::FU_LSB +: 4] == pfs_pkg::UNIT_PACKED};
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Read data
  always_ff @(posedge clk) begin
    if (rst) rdataQ <= pfs_pkg::WORD_ZERO;
    else if (clkEn && rdEn) rdataQ <= srcVal;
  end

  assign rdata              = rdataQ;
  assign padOut             = padOutQ;
  assign returnAddr         = retQ;
  assign xyEqual            = (xQ == yQ);
  assign parallelismControl = parQ;
  assign stackDepth         = ptrQ;
  assign genL               = lQ;
  assign genT               = tQ;
  assign opX                = xQ;
  assign opY                = yQ;
endmodule

// File: verif/pfs_decoder_model.sv
// Decoder stand-in that issues moves, operations, calls and returns.
// Assumes the bench calls step once for every cycle it drives.
`timescale 1ns/100ps
module pfs_decoder_model (
  // Clock
  input  wire logic                      clk,
  // Requests
  output pfs_pkg::pfs_move_s             move,
  output pfs_pkg::pfs_op_s               op,
  output logic                           call,
  output logic [pfs_pkg::MAP_W-1:0]      nextMicroAddr,
  output logic                           ret
);
  // ==========
  // Drive
  initial begin
    move = '0;
    op = '0;
    call = 1'b0;
    nextMicroAddr = '0;
    ret = 1'b0;
  end
  // Requests change just after an edge; idle wdata and address lines show the inverse
  task automatic step(input pfs_pkg::pfs_move_s m, input pfs_pkg::pfs_op_s o, input logic c, input logic r,
                      input logic [pfs_pkg::MAP_W-1:0] a);
    pfs_pkg::pfs_move_s              mNext;
    logic [pfs_pkg::MAP_W-1:0]       aNext;
    mNext = m;
    aNext = a;
    @(posedge clk);
    if (!m.valid) mNext.wdata = ~move.wdata;
    if (!c) aNext = ~nextMicroAddr;
    move <= mNext;
    op <= o;
    call <= c;
    ret <= r;
    nextMicroAddr <= aNext;
  endtask
endmodule

// File: verif/pfs_regs_properties.sv
// Checker for the field and stack register file.
// Assumes it is bound into pfs_regs and sees only its ports.
`timescale 1ns/100ps
module pfs_regs_checker #(
  parameter int WORD_W      = pfs_pkg::WORD_W,
  parameter int STACK_WORDS = pfs_pkg::STACK_WORDS
) (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic                       clkEn,
  // Requests
  input wire pfs_pkg::pfs_move_s         move,
  input wire pfs_pkg::pfs_op_s           op,
  input wire logic                       call,
  input wire logic [pfs_pkg::MAP_W-1:0]  nextMicroAddr,
  input wire logic                       ret,
  // Results
  input wire logic [WORD_W-1:0]          rdata,
  input wire logic [pfs_pkg::DESC_W-1:0] padOut,
  input wire logic [pfs_pkg::MAP_W-1:0]  returnAddr,
  input wire logic                       xyEqual,
  input wire logic [1:0]                 parallelismControl,
  input wire logic [pfs_pkg::PTR_W-1:0]  stackDepth,
  input wire logic [WORD_W-1:0]          genL,
  input wire logic [WORD_W-1:0]          genT,
  input wire logic [WORD_W-1:0]          opX,
  input wire logic [WORD_W-1:0]          opY
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic mvOk;
  logic opOk;
  assign mvOk = move.valid && clkEn && !op.valid && !call && !ret;
  assign opOk = op.valid && clkEn && !move.valid && !call && !ret;
  sequence callThenRet;
    (call && clkEn && !ret && !move.valid) ##1 (ret && clkEn && !call && !move.valid);
  endsequence
  // ==========
  // Assertions
  AST_XY_EQUAL: assert property (xyEqual == (opX == opY))
    else $error("xyEqual does not follow X and Y");
  AST_PUSH: assert property (mvOk && move.dst == pfs_pkg::SEL_STACK && move.src != pfs_pkg::SEL_STACK
    |=> stackDepth == $past(stackDepth) + 5'h01) else $error("push did not raise depth");
  AST_POP: assert property (mvOk && move.src == pfs_pkg::SEL_STACK && move.dst != pfs_pkg::SEL_STACK
    |=> stackDepth == $past(stackDepth) - 5'h01) else $error("pop did not lower depth");
  AST_CALL: assert property (call && clkEn && !ret && !move.valid
    |=> stackDepth == $past(stackDepth) + 5'h01) else $error("call did not push");
  AST_RETURN: assert property (callThenRet |=> returnAddr == $past(nextMicroAddr, 2))
    else $error("return address lost");
  AST_X_WRITE: assert property (mvOk && move.dst == pfs_pkg::SEL_OP_X |=> opX == $past(move.wdata))
    else $error("X not written whole");
  AST_L_NIBBLE: assert property (mvOk && move.dst == pfs_pkg::SEL_LA
    |=> genL == {$past(move.wdata[3:0]), $past(genL[19:0])}) else $error("L group write wrong");
  AST_T_NIBBLE: assert property (mvOk && move.dst == pfs_pkg::SEL_TF
    |=> genT == {$past(genT[23:4]), $past(move.wdata[3:0])}) else $error("T group write wrong");
  AST_BIAS: assert property ((mvOk && move.dst == pfs_pkg::SEL_UNIT) ##1 (opOk && op.op == pfs_pkg::OP_BIAS_UNIT)
    |=> parallelismControl[0] == ($past(move.wdata[3:0], 2) == pfs_pkg::UNIT_PACKED)) else $error("bias wrong");
  COV_PUSH: cover property (mvOk && move.dst == pfs_pkg::SEL_STACK);
  COV_RETURN: cover property (callThenRet);
  COV_BIAS: cover property (opOk && op.op == pfs_pkg::OP_BIAS_UNIT);
endmodule
bind pfs_regs pfs_regs_checker #(.WORD_W(WORD_W), .STACK_WORDS(STACK_WORDS)) i_pfs_regs_checker (.clk, .rst, .clkEn,
  .move, .op, .call, .nextMicroAddr, .ret, .rdata, .padOut, .returnAddr, .xyEqual, .parallelismControl, .stackDepth,
  .genL, .genT, .opX, .opY);

// File: verif/pfs_regs_test.sv
// Self-checking bench for the field and stack register file.
// Assumes the decoder model issues every request one edge at a time.
`timescale 1ns/100ps
module pfs_regs_test;
  typedef struct {
    pfs_pkg::pfs_sel_e dst;
    logic [23:0]       wd;
    pfs_pkg::pfs_sel_e src;
    logic [23:0]       exp;
  } pfs_row_s;
  logic                       clk, rst, clkEn, call, ret, xyEqual;
  pfs_pkg::pfs_move_s         move;
  pfs_pkg::pfs_op_s           op;
  logic [pfs_pkg::MAP_W-1:0]  nextMicroAddr, returnAddr;
  logic [23:0]                rdata, genL, genT, opX, opY;
  logic [pfs_pkg::DESC_W-1:0] padOut;
  logic [1:0]                 parallelismControl;
  logic [pfs_pkg::PTR_W-1:0]  stackDepth;
  int                         failures, checks_done;
  pfs_row_s                   rows [11];
  pfs_regs i_pfs_regs (.clk, .rst, .clkEn, .move, .rdata, .op, .padOut, .call, .nextMicroAddr, .ret, .returnAddr,
    .xyEqual, .parallelismControl, .stackDepth, .genL, .genT, .opX, .opY);
  pfs_decoder_model i_pfs_decoder_model (.clk, .move, .op, .call, .nextMicroAddr, .ret);
  // ==========
  // Tasks
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic mv(input pfs_pkg::pfs_sel_e s, input pfs_pkg::pfs_sel_e d, input logic [23:0] w);
    i_pfs_decoder_model.step('{1'b1, s, d, w}, '0, 1'b0, 1'b0, '0);
  endtask
  task automatic opr(input pfs_pkg::pfs_op_e o, input pfs_pkg::pfs_sel_e t, input logic [4:0] a, input logic [47:0] p);
    i_pfs_decoder_model.step('0, '{1'b1, o, t, a, 5'h04, p}, 1'b0, 1'b0, '0);
  endtask
  task automatic idle();
    i_pfs_decoder_model.step('0, '0, 1'b0, 1'b0, '0);
    #1;
  endtask
  task automatic rd(input pfs_pkg::pfs_sel_e s, input logic [23:0] e);
    mv(s, pfs_pkg::SEL_NONE, 24'h000000);
    idle();
    chk(rdata, e);
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    end_sim();
  end
  // ==========
  // Main sequence
  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    failures = 0;
    checks_done = 0;
    rows = '{'{pfs_pkg::SEL_GEN_L, 24'h123456, pfs_pkg::SEL_GEN_L, 24'h123456},
      '{pfs_pkg::SEL_LA, 24'h00000F, pfs_pkg::SEL_GEN_L, 24'hF23456},
      '{pfs_pkg::SEL_GEN_T, 24'hABCDEF, pfs_pkg::SEL_GEN_T, 24'hABCDEF},
      '{pfs_pkg::SEL_TF, 24'h000000, pfs_pkg::SEL_GEN_T, 24'hABCDE0},
      '{pfs_pkg::SEL_OP_X, 24'h0F0F0F, pfs_pkg::SEL_OP_X, 24'h0F0F0F},
      '{pfs_pkg::SEL_OP_Y, 24'h0F0F0F, pfs_pkg::SEL_OP_Y, 24'h0F0F0F},
      '{pfs_pkg::SEL_DESC_ADDR, 24'hFFFFFF, pfs_pkg::SEL_DESC_ADDR, 24'hFFFFFF},
      '{pfs_pkg::SEL_DESC_LOW, 24'h4A1234, pfs_pkg::SEL_DESC_LOW, 24'h4A1234},
      '{pfs_pkg::SEL_KIND, 24'h000007, pfs_pkg::SEL_KIND, 24'h000007},
      '{pfs_pkg::SEL_LEN, 24'h00FFFF, pfs_pkg::SEL_LEN, 24'h00FFFF},
      '{pfs_pkg::SEL_LEN_F, 24'h000000, pfs_pkg::SEL_DESC_LOW, 24'h47FFF0}};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({genL, opX}, 48'h000000000000);
    foreach (rows[i]) begin
      mv(pfs_pkg::SEL_NONE, rows[i].dst, rows[i].wd);
      rd(rows[i].src, rows[i].exp);
    end
    chk(xyEqual, 1'b1);
    opr(pfs_pkg::OP_SHL, pfs_pkg::SEL_OP_X, 5'h04, 48'h0);
    idle();
    chk({xyEqual, opX}, 25'h0F0F0F0);
    opr(pfs_pkg::OP_XY_SHL, pfs_pkg::SEL_OP_X, 5'h04, 48'h0);
    idle();
    chk({opX, opY}, 48'h0F0F00F0F0F0);
    opr(pfs_pkg::OP_EXTRACT_T, pfs_pkg::SEL_GEN_T, 5'h08, 48'h0);
    idle();
    chk(genT, 24'h00000D);
    opr(pfs_pkg::OP_ROR, pfs_pkg::SEL_GEN_T, 5'h04, 48'h0);
    idle();
    chk(genT, 24'hD00000);
    opr(pfs_pkg::OP_XY_ROR, pfs_pkg::SEL_NONE, 5'h04, 48'h0);
    idle();
    chk({opX, opY}, 48'h00F0F00F0F0F);
    opr(pfs_pkg::OP_SHR, pfs_pkg::SEL_OP_Y, 5'h04, 48'h0);
    idle();
    chk({xyEqual, opY}, 25'h100F0F0);
    opr(pfs_pkg::OP_DESC_STORE, pfs_pkg::SEL_NONE, 5'h00, 48'h0);
    idle();
    chk(padOut, 48'hFFFFFF47FFF0);
    opr(pfs_pkg::OP_DESC_LOAD, pfs_pkg::SEL_NONE, 5'h00, 48'h123456400ABC);
    rd(pfs_pkg::SEL_DESC_ADDR, 24'h123456);
    rd(pfs_pkg::SEL_LEN, 24'h000ABC);
    opr(pfs_pkg::OP_DESC_SWAP, pfs_pkg::SEL_NONE, 5'h00, 48'h0);
    idle();
    chk(padOut, 48'h123456400ABC);
    rd(pfs_pkg::SEL_DESC_LOW, 24'h000000);
    for (int u = 4; u >= 0; u -= 4) begin
      mv(pfs_pkg::SEL_NONE, pfs_pkg::SEL_UNIT, 24'(u));
      opr(pfs_pkg::OP_BIAS_UNIT, pfs_pkg::SEL_UNIT, 5'h00, 48'h0);
      idle();
      chk(parallelismControl[0], u == 4);
    end
    mv(pfs_pkg::SEL_NONE, pfs_pkg::SEL_LEN, 24'h000000);
    opr(pfs_pkg::OP_LEN_DEC, pfs_pkg::SEL_LEN, 5'h00, 48'h0);
    rd(pfs_pkg::SEL_LEN, 24'h000000);
    mv(pfs_pkg::SEL_NONE, pfs_pkg::SEL_LEN, 24'h00FFFF);
    opr(pfs_pkg::OP_LEN_INC, pfs_pkg::SEL_LEN, 5'h00, 48'h0);
    rd(pfs_pkg::SEL_LEN, 24'h000000);
    for (int i = 1; i <= 3; i++) mv(pfs_pkg::SEL_NONE, pfs_pkg::SEL_STACK, 24'(i));
    idle();
    chk(stackDepth, 5'h03);
    for (int i = 3; i >= 1; i--) rd(pfs_pkg::SEL_STACK, 24'(i));
    for (int i = 1; i <= 32; i++) mv(pfs_pkg::SEL_NONE, pfs_pkg::SEL_STACK, 24'(i));
    idle();
    chk(stackDepth, 5'h00);
    rd(pfs_pkg::SEL_STACK, 24'h000020);
    i_pfs_decoder_model.step('0, '0, 1'b1, 1'b0, 18'h2ABCD);
    i_pfs_decoder_model.step('0, '0, 1'b0, 1'b1, 18'h00000);
    idle();
    chk(returnAddr, 18'h2ABCD);
    @(posedge clk) clkEn <= 1'b0;
    mv(pfs_pkg::SEL_NONE, pfs_pkg::SEL_OP_X, 24'h123456);
    idle();
    chk(opX, 24'h00F0F0);
    @(posedge clk) clkEn <= 1'b1;
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    #1;
    chk({genT, opY, stackDepth}, 53'h0);
    end_sim();
  end
endmodule
